// ===== logic/pwr_state_pkg.sv
// pwr_state_pkg: shared constants, state encoding and carrier structs
// for the operating-state controller; assumes a 20 MHz mclk.
package pwr_state_pkg;

    // operating states
    typedef enum logic [2:0] {
        ST_POWERUP   = 3'b000,
        ST_HIBERNATE = 3'b001,
        ST_SLEEP     = 3'b010,
        ST_TAGDET    = 3'b011,
        ST_WAKING    = 3'b100,
        ST_READY     = 3'b101,
        ST_READER    = 3'b110
    } op_state_t;

    // idle target carried in the idle command argument
    localparam logic [1:0] IDLE_HIBERNATE = 2'h0;
    localparam logic [1:0] IDLE_SLEEP = 2'h1;
    localparam logic [1:0] IDLE_TAGDET = 2'h2;

    // host command codes
    localparam logic [7:0] CMD_PROTOCOL_SELECT = 8'h02;
    localparam logic [7:0] CMD_FRAME_EXCHANGE = 8'h04;
    localparam logic [7:0] CMD_IDLE = 8'h07;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SETTLE_US = 2000;
    localparam int SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;
    localparam int WAKE_PULSE_NS = 10000;
    localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SLOW_HZ = 32_000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int BURST_SLOW_TICKS = 4;

    // fields of the wake source enable set
    localparam int WK_TIMER = 0;
    localparam int WK_PULSE = 1;
    localparam int WK_NSS = 2;
    localparam int WK_FIELD = 3;

    typedef struct packed {
        logic [7:0] code;
        logic [1:0] idle_target;
        logic [3:0] wake_enable;
        logic [15:0] wake_period;
    } host_cmd_t;

    typedef struct packed {
        logic fast_osc_run;
        logic rf_field_on;
        logic cmd_accept;
        logic spi_selected;
    } op_status_t;

endpackage

// ===== logic/slow_osc_timer.sv
// slow_osc_timer: 32 kHz slow tick from mclk plus a programmable
// wake-up period counter; assumes run is held for the whole idle stay.
`timescale 1ns/10ps
module slow_osc_timer #(
    parameter int DIV = pwr_state_pkg::SLOW_DIV
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [15:0] period,
    output logic slow_tick,
    output logic expired
);
    logic [15:0] div_ff, nxt_div;
    logic [15:0] cnt_ff, nxt_cnt;
    logic tick_ff, nxt_tick;
    logic exp_ff, nxt_exp;

    // divider and period count restart whenever run drops
    always_comb
    begin
        nxt_div = div_ff;
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        nxt_exp = 1'b0;
        if (!run)
        begin
            nxt_div = 16'h0000;
            nxt_cnt = 16'h0000;
        end
        else if (div_ff == 16'(DIV - 1))
        begin
            nxt_div = 16'h0000;
            nxt_tick = 1'b1;
            if (cnt_ff + 16'h0001 >= period)
            begin
                nxt_cnt = 16'h0000;
                nxt_exp = (period != 16'h0000); // zero period never fires
            end
            else
            begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
        else
        begin
            nxt_div = div_ff + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_ff <= 16'h0000;
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
            exp_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
            exp_ff <= nxt_exp;
        end
    end

    assign slow_tick = tick_ff;
    assign expired = exp_ff;
endmodule

// ===== logic/rfid_power_state_controller.sv
// rfid_power_state_controller: idle/active operating-state sequencer of
// a 13.56 MHz reader; assumes decoded host commands arrive as one-cycle
// strobes from a serial front end, and detector inputs are synchronous.
//
// Notes on behaviour
// - hibernate is left only by a low pulse on the wake input.
// - sleep leaves on enabled timer, wake pulse, nss low or field detect.
// - tag detection always wakes on tag detect; timer, wake pulse, nss optional.
// - ready runs fast oscillator, field off, waits for host command.
// - reader runs fast oscillator, field on, still takes commands.
// - frame exchange command is only acted on in reader state.
// - idle states entered only through the idle command.
// - wake from sleep or hibernate reaches ready after 2 ms settling.
// - protocol choose command moves ready to reader.
// - ready to reader adds no settling delay.
// - 32 kHz slow oscillator times wake-ups in detection states.
// - tag or field detection drives the interrupt output.
// - tag detection uses internal sequencer for rf burst timing.
// - system clock is 13.56 MHz from 27.12 MHz crystal.
// - idle command code is 0x07.
// - protocol choose command code is 0x02.
// - rx masked while a waking pulse holds it low in sleep or tag detection; after hibernate, one cycle after it ends.
`timescale 1ns/10ps
module rfid_power_state_controller #(
    parameter int SETTLE_CYC = pwr_state_pkg::SETTLE_CYC,
    parameter int PULSE_CYC = pwr_state_pkg::WAKE_PULSE_CYC
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire pwr_state_pkg::host_cmd_t cmd,
    input wire logic wake_pulse_n,
    input wire logic nss_n,
    input wire logic if_select,
    input wire logic field_detect,
    input wire logic tag_detect,
    input wire logic xtal_ok,
    output pwr_state_pkg::op_state_t state,
    output pwr_state_pkg::op_status_t status,
    output logic sys_clk_div_en,
    output logic rf_burst,
    output logic frame_exchange_go,
    output logic uart_rx_mask,
    output logic irq_out_n
);
    pwr_state_pkg::op_state_t st_ff, nxt_st;
    logic [23:0] cnt_ff, nxt_cnt;
    logic [3:0] wk_en_ff, nxt_wk_en;
    logic [15:0] period_ff, nxt_period;
    logic spi_ff, nxt_spi;
    logic [7:0] lowcnt_ff, nxt_lowcnt;
    logic pulse_prev_ff, nxt_pulse_prev;
    logic mask_ff, nxt_mask;
    logic irq_ff, nxt_irq;
    logic burst_ff, nxt_burst;
    logic [2:0] bcnt_ff, nxt_bcnt;
    logic fx_ff, nxt_fx;
    pwr_state_pkg::op_status_t stat_ff, nxt_stat;
    logic div_ff, nxt_div;
    logic timer_run, slow_tick, timer_exp, pulse_ok, wake_hit, detect_hit;

    // wake-up timer on the slow oscillator, only in timed idle states
    assign timer_run = (st_ff == pwr_state_pkg::ST_SLEEP) ||
                       (st_ff == pwr_state_pkg::ST_TAGDET);

    slow_osc_timer #(.DIV(pwr_state_pkg::SLOW_DIV)) u_slow
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(timer_run),
        .period(period_ff),
        .slow_tick(slow_tick),
        .expired(timer_exp)
    );

    // a qualified pulse: rising edge after low for at least PULSE_CYC
    assign pulse_ok = wake_pulse_n && !pulse_prev_ff && (lowcnt_ff >= 8'(PULSE_CYC));

    // detector events that reach the host in sleep and tag detection
    assign detect_hit = ((st_ff == pwr_state_pkg::ST_TAGDET) && tag_detect) ||
                        ((st_ff == pwr_state_pkg::ST_SLEEP) && wk_en_ff[pwr_state_pkg::WK_FIELD]
                         && field_detect);

    // wake decision per idle state; hibernate wakes on the pulse whatever the enables, sleep and tag detection ignore disabled sources
    always_comb
    begin
        wake_hit = 1'b0;
        unique case (st_ff)
            pwr_state_pkg::ST_HIBERNATE:
                wake_hit = pulse_ok;
            pwr_state_pkg::ST_SLEEP:
                wake_hit = (wk_en_ff[pwr_state_pkg::WK_TIMER] && timer_exp) ||
                           (wk_en_ff[pwr_state_pkg::WK_PULSE] && !wake_pulse_n) ||
                           (wk_en_ff[pwr_state_pkg::WK_NSS] && !nss_n) ||
                           (wk_en_ff[pwr_state_pkg::WK_FIELD] && field_detect);
            pwr_state_pkg::ST_TAGDET:
                wake_hit = tag_detect ||
                           (wk_en_ff[pwr_state_pkg::WK_TIMER] && timer_exp) ||
                           (wk_en_ff[pwr_state_pkg::WK_PULSE] && !wake_pulse_n) ||
                           (wk_en_ff[pwr_state_pkg::WK_NSS] && !nss_n);
            default:
                wake_hit = 1'b0;
        endcase
    end

    // main sequencer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_wk_en = wk_en_ff;
        nxt_period = period_ff;
        nxt_spi = spi_ff;
        nxt_fx = 1'b0;
        nxt_mask = mask_ff;
        nxt_pulse_prev = wake_pulse_n;
        nxt_lowcnt = wake_pulse_n ? 8'h00 :
                     ((lowcnt_ff == 8'hff) ? lowcnt_ff : lowcnt_ff + 8'h01);
        unique case (st_ff)
            pwr_state_pkg::ST_POWERUP:
                if (pulse_ok)
                begin
                    nxt_spi = if_select;
                    nxt_cnt = 24'h000000;
                    nxt_mask = 1'b1;
                    nxt_st = pwr_state_pkg::ST_WAKING;
                end
            pwr_state_pkg::ST_HIBERNATE, pwr_state_pkg::ST_SLEEP, pwr_state_pkg::ST_TAGDET:
                if (wake_hit)
                begin
                    if (st_ff == pwr_state_pkg::ST_HIBERNATE)
                        nxt_spi = if_select; // interface reselected after hibernate
                    nxt_cnt = 24'h000000;
                    nxt_mask = !wake_pulse_n || pulse_ok;
                    nxt_st = pwr_state_pkg::ST_WAKING;
                end
            pwr_state_pkg::ST_WAKING:
            begin
                // crystal settle; count first, then wait for xtal_ok too
                if (cnt_ff >= 24'(SETTLE_CYC - 1) && xtal_ok)
                    nxt_st = pwr_state_pkg::ST_READY;
                else if (cnt_ff < 24'(SETTLE_CYC - 1))
                    nxt_cnt = cnt_ff + 24'h000001;
                if (wake_pulse_n)
                    nxt_mask = 1'b0; // unmask rx once the pulse is released
            end
            pwr_state_pkg::ST_READY, pwr_state_pkg::ST_READER:
            begin
                if (wake_pulse_n)
                    nxt_mask = 1'b0;
                if (cmd_valid && cmd.code == pwr_state_pkg::CMD_IDLE)
                begin
                    nxt_wk_en = cmd.wake_enable;
                    nxt_period = cmd.wake_period;
                    unique case (cmd.idle_target)
                        pwr_state_pkg::IDLE_HIBERNATE: nxt_st = pwr_state_pkg::ST_HIBERNATE;
                        pwr_state_pkg::IDLE_SLEEP: nxt_st = pwr_state_pkg::ST_SLEEP;
                        default: nxt_st = pwr_state_pkg::ST_TAGDET;
                    endcase
                end
                else if (cmd_valid && cmd.code == pwr_state_pkg::CMD_PROTOCOL_SELECT)
                    nxt_st = pwr_state_pkg::ST_READER; // no settle delay
                else if (cmd_valid && cmd.code == pwr_state_pkg::CMD_FRAME_EXCHANGE)
                    nxt_fx = (st_ff == pwr_state_pkg::ST_READER);
            end
            default:
                nxt_st = pwr_state_pkg::ST_POWERUP;
        endcase
    end

    // state flags, burst sequencer, interrupt and clock divider
    always_comb
    begin
        nxt_stat.fast_osc_run = (nxt_st == pwr_state_pkg::ST_READY) ||
                                (nxt_st == pwr_state_pkg::ST_READER) ||
                                (nxt_st == pwr_state_pkg::ST_WAKING);
        nxt_stat.rf_field_on = (nxt_st == pwr_state_pkg::ST_READER);
        nxt_stat.cmd_accept = (nxt_st == pwr_state_pkg::ST_READY) ||
                              (nxt_st == pwr_state_pkg::ST_READER);
        nxt_stat.spi_selected = nxt_spi;
        // burst opens on the slow tick after it closes and lasts four ticks
        nxt_burst = burst_ff;
        nxt_bcnt = bcnt_ff;
        if (st_ff != pwr_state_pkg::ST_TAGDET)
        begin
            nxt_burst = 1'b0;
            nxt_bcnt = 3'h0;
        end
        else if (slow_tick)
        begin
            if (burst_ff && bcnt_ff == 3'(pwr_state_pkg::BURST_SLOW_TICKS - 1))
            begin
                nxt_burst = 1'b0;
                nxt_bcnt = 3'h0;
            end
            else if (burst_ff)
                nxt_bcnt = bcnt_ff + 3'h1;
            else
                nxt_burst = 1'b1;
        end
        // interrupt held low until the host sends any command
        nxt_irq = irq_ff;
        if (detect_hit)
            nxt_irq = 1'b0; // set wins over clear
        else if (cmd_valid)
            nxt_irq = 1'b1;
        // divide-by-two enable, models 27.12 -> 13.56 MHz derivation
        nxt_div = nxt_stat.fast_osc_run ? !div_ff : 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= pwr_state_pkg::ST_POWERUP;
            cnt_ff <= 24'h000000;
            wk_en_ff <= 4'h0;
            period_ff <= 16'h0000;
            spi_ff <= 1'b0;
            lowcnt_ff <= 8'h00;
            pulse_prev_ff <= 1'b1;
            mask_ff <= 1'b0;
            irq_ff <= 1'b1;
            burst_ff <= 1'b0;
            bcnt_ff <= 3'h0;
            fx_ff <= 1'b0;
            stat_ff <= '0;
            div_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            wk_en_ff <= nxt_wk_en;
            period_ff <= nxt_period;
            spi_ff <= nxt_spi;
            lowcnt_ff <= nxt_lowcnt;
            pulse_prev_ff <= nxt_pulse_prev;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            burst_ff <= nxt_burst;
            bcnt_ff <= nxt_bcnt;
            fx_ff <= nxt_fx;
            stat_ff <= nxt_stat;
            div_ff <= nxt_div;
        end
    end

    assign state = st_ff;
    assign status = stat_ff;
    assign sys_clk_div_en = div_ff;
    assign rf_burst = burst_ff;
    assign frame_exchange_go = fx_ff;
    assign uart_rx_mask = mask_ff;
    assign irq_out_n = irq_ff;
endmodule

// ===== dv/rfid_power_state_controller_sva.sv
// port checker for the operating-state controller
// assumes one clock domain with an async active-low reset
`timescale 1ns/10ps
module rfid_power_state_controller_sva #(
    parameter int SETTLE_CYC = pwr_state_pkg::SETTLE_CYC
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire pwr_state_pkg::host_cmd_t cmd,
    input wire logic wake_pulse_n,
    input wire logic tag_detect,
    input wire pwr_state_pkg::op_state_t state,
    input wire pwr_state_pkg::op_status_t status,
    input wire logic frame_exchange_go,
    input wire logic irq_out_n
);
    int wait_cnt_ff;
    int nxt_wait_cnt;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // cycles spent settling; cleared outside the waking state
    always_comb
        nxt_wait_cnt = (state == pwr_state_pkg::ST_WAKING) ? wait_cnt_ff + 1 : 0;
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            wait_cnt_ff <= 0;
        else
            wait_cnt_ff <= nxt_wait_cnt;
    property p_ready_run;
        state == pwr_state_pkg::ST_READY |-> status.fast_osc_run && !status.rf_field_on;
    endproperty
    a_ready_run: assert property (p_ready_run) else $error("ready outputs wrong");
    property p_reader_run;
        state == pwr_state_pkg::ST_READER |-> status.fast_osc_run && status.rf_field_on;
    endproperty
    a_reader_run: assert property (p_reader_run) else $error("reader outputs wrong");
    property p_sleep_cmd;
        cmd_valid && cmd.code == 8'h07 && cmd.idle_target == 2'h1 && state[2] && state[1:0] != 0
            |=> state == pwr_state_pkg::ST_SLEEP;
    endproperty
    a_sleep_cmd: assert property (p_sleep_cmd) else $error("no sleep entry");
    property p_select;
        cmd_valid && cmd.code == 8'h02 && state == pwr_state_pkg::ST_READY
            |=> state == pwr_state_pkg::ST_READER;
    endproperty
    a_select: assert property (p_select) else $error("no reader entry");
    property p_go;
        frame_exchange_go |-> $past(cmd_valid) && $past(cmd.code) == 8'h04
            && $past(state) == pwr_state_pkg::ST_READER;
    endproperty
    a_go: assert property (p_go) else $error("stray frame exchange");
    property p_idle_cause;
        $changed(state) && state inside {[3'h1:3'h3]} |-> $past(cmd_valid);
    endproperty
    a_idle_cause: assert property (p_idle_cause) else $error("idle without command");
    property p_hib_stay;
        state == pwr_state_pkg::ST_HIBERNATE && wake_pulse_n && $past(wake_pulse_n)
            |=> state == pwr_state_pkg::ST_HIBERNATE;
    endproperty
    a_hib_stay: assert property (p_hib_stay) else $error("hibernate left early");
    property p_tag_wake;
        state == pwr_state_pkg::ST_TAGDET && tag_detect
            |=> state == pwr_state_pkg::ST_WAKING && !irq_out_n;
    endproperty
    a_tag_wake: assert property (p_tag_wake) else $error("tag detect missed");
    // a slow crystal may stretch the wait only by a cycle or two
    property p_settle;
        state == pwr_state_pkg::ST_READY && $past(state) == pwr_state_pkg::ST_WAKING
            |-> wait_cnt_ff >= SETTLE_CYC - 2 && wait_cnt_ff <= SETTLE_CYC + 2;
    endproperty
    a_settle: assert property (p_settle) else $error("settle time wrong");
    c_sleep: cover property (state == pwr_state_pkg::ST_SLEEP ##1 state == pwr_state_pkg::ST_WAKING);
    c_hib: cover property (state == pwr_state_pkg::ST_HIBERNATE ##1 !state[1]);
    c_go: cover property ($rose(frame_exchange_go));
endmodule
bind rfid_power_state_controller rfid_power_state_controller_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (
    .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .wake_pulse_n(wake_pulse_n), .tag_detect(tag_detect), .state(state), .status(status),
    .frame_exchange_go(frame_exchange_go), .irq_out_n(irq_out_n));

// ===== dv/host_model.sv
// host stand-in: decoded command strobes and the two wake pins
// assumes the controller clock; drives 2 ns after a rising edge
`timescale 1ns/10ps
module host_model
(
    input wire logic mclk,
    output logic cmd_valid,
    output pwr_state_pkg::host_cmd_t cmd,
    output logic wake_pulse_n,
    output logic nss_n
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
        wake_pulse_n = 1'b1;
        nss_n = 1'b1;
    end
    // one-cycle strobe; lines scrambled after so nothing stale lingers
    task automatic send(input logic [7:0] code, input logic [1:0] tgt, input logic [3:0] en,
        input logic [15:0] per = 16'h0000);
        @(posedge mclk);
        #2;
        cmd_valid = 1'b1;
        cmd = {code, tgt, en, per};
        @(posedge mclk);
        #2;
        cmd_valid = 1'b0;
        cmd = ~cmd;
    endtask
    // low level on the wake input or the select pin for n cycles
    task automatic low(input logic sel, input int n);
        @(posedge mclk);
        #2;
        nss_n = !sel;
        wake_pulse_n = sel;
        repeat (n) @(posedge mclk);
        #2;
        nss_n = 1'b1;
        wake_pulse_n = 1'b1;
    endtask
endmodule

// ===== dv/rfid_power_state_controller_tb.sv
// random and corner-case bench for the operating-state controller
// assumes the host model as far side; settle and pulse counts shortened
`timescale 1ns/10ps
module rfid_power_state_controller_tb;
    localparam int SETTLE = 20;
    localparam int PULSE = 10;
    logic mclk, reset_n, if_select, field_detect, tag_detect, xtal_ok;
    logic cmd_valid, wake_pulse_n, nss_n, sys_clk_div_en, rf_burst, frame_exchange_go;
    logic uart_rx_mask, irq_out_n, spi;
    pwr_state_pkg::host_cmd_t cmd;
    pwr_state_pkg::op_state_t state;
    pwr_state_pkg::op_status_t status;
    int failures, check_count, off, on, hi;
    int mask_hi, mark;
    logic [1:0] tgt;
    logic [3:0] en;
    host_model u_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd),
        .wake_pulse_n(wake_pulse_n), .nss_n(nss_n));
    rfid_power_state_controller #(.SETTLE_CYC(SETTLE), .PULSE_CYC(PULSE))
        u_rfid_power_state_controller (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .wake_pulse_n(wake_pulse_n), .nss_n(nss_n), .if_select(if_select),
        .field_detect(field_detect), .tag_detect(tag_detect), .xtal_ok(xtal_ok),
        .state(state), .status(status), .sys_clk_div_en(sys_clk_div_en), .rf_burst(rf_burst),
        .frame_exchange_go(frame_exchange_go), .uart_rx_mask(uart_rx_mask),
        .irq_out_n(irq_out_n));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // rx mask history; after a hibernate wake the mask stands one cycle only
    always @(negedge mclk)
        if (uart_rx_mask === 1'b1)
            mask_hi++;
    task automatic final_report();
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // bounded wait; running out ends the run
    task automatic wait_st(input pwr_state_pkg::op_state_t s, input int lim);
        for (int i = 0; i < lim && state !== s; i++)
            @(negedge mclk);
        chk("reached state", s, state);
        if (state !== s)
            final_report();
    endtask
    // sources: 1 wake pin, 2 select pin, 3 field, 4 tag
    task automatic poke(input int s, input int n);
        if (s < 3)
            u_host_model.low(s == 2, n);
        else
        begin
            @(posedge mclk);
            #2;
            field_detect = (s == 3);
            tag_detect = (s == 4);
            repeat (n) @(posedge mclk);
            #2;
            field_detect = 1'b0;
            tag_detect = 1'b0;
        end
        repeat (2) @(posedge mclk);
        #2;
    endtask
    function automatic logic exp_wake(logic [1:0] t, logic [3:0] e, int s);
        if (t == pwr_state_pkg::IDLE_HIBERNATE)
            return s == 1;
        if (s == 4)
            return t == pwr_state_pkg::IDLE_TAGDET;
        return e[s];
    endfunction
    function automatic pwr_state_pkg::op_state_t idle_of(logic [1:0] t);
        return pwr_state_pkg::op_state_t'({1'b0, t == 0 ? 2'h1 : t == 1 ? 2'h2 : 2'h3});
    endfunction
    initial
    begin
        reset_n = 1'b0;
        field_detect = 1'b0;
        tag_detect = 1'b0;
        xtal_ok = 1'b1;
        void'($urandom(7));
        spi = 1'($urandom % 2);
        if_select = spi;
        repeat (8) @(posedge mclk);
        #2;
        reset_n = 1'b1;
        chk("irq idle", 1, irq_out_n);
        poke(1, PULSE - 3);
        chk("short pulse", pwr_state_pkg::ST_POWERUP, state);
        poke(1, PULSE + 2);
        wait_st(pwr_state_pkg::ST_WAKING, 4);
        repeat (SETTLE - 4) @(negedge mclk);
        chk("still settling", pwr_state_pkg::ST_WAKING, state);
        wait_st(pwr_state_pkg::ST_READY, 8);
        chk("ready status", {3'h5, spi}, status);
        hi = sys_clk_div_en;
        @(negedge mclk);
        chk("clock divider", hi ^ 1, sys_clk_div_en);
        chk("interface", spi, status.spi_selected);
        u_host_model.send(pwr_state_pkg::CMD_FRAME_EXCHANGE, 0, 0);
        chk("go in ready", 0, frame_exchange_go);
        u_host_model.send(pwr_state_pkg::CMD_PROTOCOL_SELECT, 0, 0);
        chk("reader now", pwr_state_pkg::ST_READER, state);
        chk("reader status", {3'h7, spi}, status);
        u_host_model.send(pwr_state_pkg::CMD_FRAME_EXCHANGE, 0, 0);
        chk("go in reader", 1, frame_exchange_go);
        for (int k = 0; k < 6; k++)
        begin
            tgt = 2'(k % 3);
            en = 4'($urandom);
            off = tgt == 0 ? 2 + $urandom % 2 : 1 + $urandom % (tgt == 1 ? 3 : 2);
            on = tgt == 0 ? 1 : tgt == 2 ? 4 : off % 3 + 1;
            en[0] = 1'b0;
            en[off] = 1'b0;
            if (on < 4)
                en[on] = 1'b1;
            u_host_model.send(pwr_state_pkg::CMD_IDLE, tgt, en);
            chk("idle entry", idle_of(tgt), state);
            chk("idle status", {3'h0, spi}, status);
            chk("divider stopped", 0, sys_clk_div_en);
            hi = 0;
            // one full burst period: 4 ticks on, 1 off
            if (tgt == 2)
                repeat (5 * pwr_state_pkg::SLOW_DIV) @(negedge mclk) hi += rf_burst;
            chk("burst time", tgt == 2, hi > 2400 && hi < 2600);
            poke(off, 3);
            chk("ignored source", idle_of(tgt), state);
            mark = mask_hi;
            poke(on, tgt == 0 ? PULSE + 2 : 3);
            chk("woken", exp_wake(tgt, en, on), state == pwr_state_pkg::ST_WAKING);
            chk("rx masked", on == 1, mask_hi != mark);
            chk("irq level", on < 3, irq_out_n);
            wait_st(pwr_state_pkg::ST_READY, SETTLE + 4);
            if ($urandom % 2)
                u_host_model.send(pwr_state_pkg::CMD_PROTOCOL_SELECT, 0, 0);
        end
        // timed wake from sleep: period of two slow ticks, timer the only source
        u_host_model.send(pwr_state_pkg::CMD_IDLE, pwr_state_pkg::IDLE_SLEEP, 4'h1, 16'h0002);
        repeat (2 * pwr_state_pkg::SLOW_DIV - 10) @(negedge mclk);
        chk("timer early", pwr_state_pkg::ST_SLEEP, state);
        wait_st(pwr_state_pkg::ST_WAKING, 20);
        wait_st(pwr_state_pkg::ST_READY, SETTLE + 4);
        final_report();
    end
endmodule
